//--- hdl/qpc_map.vh
// register map, field positions, reset values and codes of the quadrature pulse counter
// assumes a 32-bit apb slave with word-aligned registers
`ifndef QPC_MAP_VH
`define QPC_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define QPC_OFS_CTRL     8'h00
`define QPC_OFS_PRESET   8'h04
`define QPC_OFS_COUNT    8'h08
`define QPC_OFS_ERR      8'h0C
`define QPC_OFS_IRQ_STAT 8'h10
`define QPC_OFS_IRQ_MASK 8'h14

// ****************************************************************
// control register fields
// ****************************************************************
`define QPC_CTRL_EN      0
`define QPC_CTRL_MODE_LO 1
`define QPC_CTRL_MODE_HI 2
`define QPC_CTRL_MUL_LO  3
`define QPC_CTRL_MUL_HI  4
`define QPC_CTRL_DOWN    5
`define QPC_CTRL_PSRC    6
`define QPC_CTRL_PREQ    7
`define QPC_CTRL_W       8
`define QPC_CTRL_RST     8'h00

// ****************************************************************
// mode and multiplier encodings
// ****************************************************************
`define QPC_MODE_PROG    2'h0
`define QPC_MODE_BDIR    2'h1
`define QPC_MODE_QUAD    2'h2
`define QPC_MUL_X1       2'h0
`define QPC_MUL_X2       2'h1
`define QPC_MUL_X4       2'h2
`define QPC_MUL_BAD      2'h3

// ****************************************************************
// error codes, interrupt bits and count limits
// ****************************************************************
`define QPC_ERR_NONE     8'h00
`define QPC_ERR_FACTOR   8'h02
`define QPC_ERR_DISABLED 8'h04
`define QPC_IRQ_W        4
`define QPC_IRQ_PRESET   0
`define QPC_IRQ_PERR     1
`define QPC_IRQ_OVF      2
`define QPC_IRQ_UNF      3
`define QPC_CNT_RST      24'h000000
`define QPC_CNT_MAX      24'hFFFFFF

`endif

//--- hdl/qpc_sync_edge.v
// two-flop synchroniser with rise and fall detection for one input pin
// assumes the pin may change at any time relative to pclk
`timescale 1ns/10ps
`default_nettype none

module qpc_sync_edge (
  input  wire pclk,
  input  wire presetn,
  input  wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_r;
  reg sync_r;
  reg last_r;

  // ****************************************************************
  // synchroniser and edge history
  // ****************************************************************
  // meta_r feeds only sync_r; edges are taken from the settled stages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // edge pulses last one cycle
  assign level = sync_r;
  assign rise  = sync_r & ~last_r;
  assign fall  = ~sync_r & last_r;

endmodule
`default_nettype wire

//--- hdl/qpc_counter.v
// quadrature pulse counter: 24-bit counter with apb registers and one level interrupt
// assumes apb signals synchronous to pclk; phase and preset pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "qpc_map.vh"

// Summary of operation
// - one-phase program mode: count phase A pulses, direction from control bit
// - one-phase B mode: count phase A pulses, direction from phase B level
// - two-phase mode: direction chosen from phase relation of A and B
// - multiply by one, two or four applies only in two-phase mode
// - times one: count only on phase A rising edges
// - times two: count on phase A rising and falling edges
// - times four: count on every edge of phase A, and on phase B edges in cycles with no phase A edge
// - count is unsigned 24-bit, zero to full 24-bit maximum
// - preset load source selectable: program request or external preset pin
// - while count enable is zero the count is forced to zero
// - program preset: load preset value on rising edge of preset request
// - external preset: load on preset pin rising edge, ignore program request
// - preset while disabled does not load, reports error code 04
module qpc_counter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        phase_a,
  input  wire        phase_b,
  input  wire        preset_pin,
  output reg         irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg  [`QPC_CTRL_W-1:0] ctrl_r;
  reg  [23:0]            preset_val_r;
  reg  [23:0]            count_r;
  reg  [23:0]            count_nxt;
  reg  [7:0]             err_r;
  reg  [7:0]             err_nxt;
  reg  [`QPC_IRQ_W-1:0]  irq_stat_r;
  reg  [`QPC_IRQ_W-1:0]  irq_mask_r;
  reg  [`QPC_IRQ_W-1:0]  irq_evt;
  reg  [31:0]            rd_mux;
  reg                    rd_hit;
  reg                    step;
  reg                    up;
  reg                    preset_go;
  reg                    preset_try;
  wire                   a_lvl;
  wire                   a_rise;
  wire                   a_fall;
  wire                   b_lvl;
  wire                   b_rise;
  wire                   b_fall;
  wire                   pre_rise;
  wire                   wr_ctrl;
  wire                   wr_en;
  wire                   cnt_en;
  wire [1:0]             phase_mode_select;
  wire [1:0]             multiply_factor;
  wire                   prog_req_rise;
  wire [`QPC_CTRL_W-1:0] ctrl_wdata;

  // ****************************************************************
  // helper: wrapping 24-bit step
  // ****************************************************************
  // the count wraps modulo 2^24; wrap events are flagged separately
  function [23:0] qpc_step;
    input [23:0] cur;
    input        go_up;
    begin
      if (go_up) begin
        qpc_step = cur + 24'h000001;
      end else begin
        qpc_step = cur - 24'h000001;
      end
    end
  endfunction

  // ****************************************************************
  // helper: control word field decode
  // ****************************************************************
  // shared by the stored word and by the word on its way in
  function [1:0] qpc_mode;
    input [`QPC_CTRL_W-1:0] word;
    begin
      qpc_mode = word[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO];
    end
  endfunction

  function [1:0] qpc_mul;
    input [`QPC_CTRL_W-1:0] word;
    begin
      qpc_mul = word[`QPC_CTRL_MUL_HI:`QPC_CTRL_MUL_LO];
    end
  endfunction

  // ****************************************************************
  // helper: direction of one quadrature edge
  // ****************************************************************
  // a rise counts up while the other phase is low, a fall while it is
  // high; a b edge passes the inverted a level so one rule serves both
  function qpc_dir;
    input edge_rise;
    input other_lvl;
    begin
      if (edge_rise) begin
        qpc_dir = ~other_lvl;
      end else begin
        qpc_dir = other_lvl;
      end
    end
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // all three pins pass through two flops before any edge logic
  qpc_sync_edge u_sync_a (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (phase_a),
    .level   (a_lvl),
    .rise    (a_rise),
    .fall    (a_fall)
  );

  qpc_sync_edge u_sync_b (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (phase_b),
    .level   (b_lvl),
    .rise    (b_rise),
    .fall    (b_fall)
  );

  qpc_sync_edge u_sync_p (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (preset_pin),
    .level   (),
    .rise    (pre_rise),
    .fall    ()
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // writes take effect at the access edge where pready is high
  // an unmapped write changes nothing; pslverr is the master's only sign
  assign wr_en      = psel & penable & pready & pwrite;
  assign wr_ctrl    = wr_en & (paddr == `QPC_OFS_CTRL);
  assign ctrl_wdata = pwdata[`QPC_CTRL_W-1:0];
  assign cnt_en     = ctrl_r[`QPC_CTRL_EN];
  assign phase_mode_select = qpc_mode(ctrl_r);
  assign multiply_factor   = qpc_mul(ctrl_r);

  // request bit is a level; only its 0 to 1 write counts as a request
  assign prog_req_rise = wr_ctrl & ctrl_wdata[`QPC_CTRL_PREQ] & ~ctrl_r[`QPC_CTRL_PREQ];

  // read mux; unmapped addresses read zero and raise pslverr
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `QPC_OFS_CTRL:     rd_mux[`QPC_CTRL_W-1:0] = ctrl_r;
      `QPC_OFS_PRESET:   rd_mux[23:0] = preset_val_r;
      `QPC_OFS_COUNT:    rd_mux[23:0] = count_r;
      `QPC_OFS_ERR:      rd_mux[7:0] = err_r;
      `QPC_OFS_IRQ_STAT: rd_mux[`QPC_IRQ_W-1:0] = irq_stat_r;
      `QPC_OFS_IRQ_MASK: rd_mux[`QPC_IRQ_W-1:0] = irq_mask_r;
      default:           rd_hit = 1'b0;
    endcase
  end

  // zero-wait slave: pready rises for the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // control selects mode, multiplier, direction and preset source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r       <= `QPC_CTRL_RST;
      preset_val_r <= `QPC_CNT_RST;
      irq_mask_r   <= {`QPC_IRQ_W{1'b0}};
    end else if (wr_en) begin
      if (paddr == `QPC_OFS_CTRL) begin
        ctrl_r <= ctrl_wdata;
      end
      if (paddr == `QPC_OFS_PRESET) begin
        preset_val_r <= pwdata[23:0];
      end
      if (paddr == `QPC_OFS_IRQ_MASK) begin
        irq_mask_r <= pwdata[`QPC_IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // step and direction decode
  // ****************************************************************
  // in quadrature, A leads B when B is low at A rise or high at A fall
  always @* begin
    step = 1'b0;
    up   = 1'b1;
    case (phase_mode_select)
      `QPC_MODE_PROG: begin
        step = a_rise;
        up   = ~ctrl_r[`QPC_CTRL_DOWN];
      end
      `QPC_MODE_BDIR: begin
        step = a_rise;
        up   = ~b_lvl;
      end
      `QPC_MODE_QUAD: begin
        // multiplier is read only here, so it is a no-op in one-phase modes
        case (multiply_factor)
          `QPC_MUL_X1: begin
            // b edges are ignored here; b only gives the sense at an a rise
            step = a_rise;
            up   = ~b_lvl;
          end
          `QPC_MUL_X2: begin
            step = a_rise | a_fall;
            up   = qpc_dir(a_rise, b_lvl);
          end
          `QPC_MUL_X4: begin
            // an A edge wins if both phases move in one cycle
            if (a_rise | a_fall) begin
              step = 1'b1;
              up   = qpc_dir(a_rise, b_lvl);
            end else begin
              step = b_rise | b_fall;
              up   = qpc_dir(b_rise, ~a_lvl);
            end
          end
          default: begin
            step = 1'b0;
            up   = 1'b1;
          end
        endcase
      end
      default: begin
        step = 1'b0;
        up   = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // preset arbitration
  // ****************************************************************
  // external source masks the program request entirely
  always @* begin
    if (ctrl_r[`QPC_CTRL_PSRC]) begin
      preset_try = pre_rise;
    end else begin
      preset_try = prog_req_rise;
    end
    preset_go = preset_try & cnt_en;
  end

  // ****************************************************************
  // count and error code next state
  // ****************************************************************
  // priority: disable clear, then preset, then counting
  // a step that meets a preset in one cycle is lost; the preset stands
  // wrap flags come from steps only, a preset to any value never flags
  always @* begin
    count_nxt = count_r;
    err_nxt   = err_r;
    irq_evt   = {`QPC_IRQ_W{1'b0}};
    if (!cnt_en) begin
      count_nxt = `QPC_CNT_RST;
    end else if (preset_go) begin
      count_nxt = preset_val_r;
    end else if (step) begin
      count_nxt = qpc_step(count_r, up);
      irq_evt[`QPC_IRQ_OVF] = up & (count_r == `QPC_CNT_MAX);
      irq_evt[`QPC_IRQ_UNF] = ~up & (count_r == `QPC_CNT_RST);
    end
    if (preset_try & ~cnt_en) begin
      err_nxt = `QPC_ERR_DISABLED;
      irq_evt[`QPC_IRQ_PERR] = 1'b1;
    end else if (preset_go) begin
      err_nxt = `QPC_ERR_NONE;
      irq_evt[`QPC_IRQ_PRESET] = 1'b1;
    end else if (wr_ctrl && qpc_mode(ctrl_wdata) == `QPC_MODE_QUAD
                 && qpc_mul(ctrl_wdata) == `QPC_MUL_BAD) begin
      // an undefined multiplier stops quadrature counting
      err_nxt = `QPC_ERR_FACTOR;
    end
  end

  // ****************************************************************
  // count, error and interrupt state
  // ****************************************************************
  // status bits are write-one-to-clear; a new event wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r    <= `QPC_CNT_RST;
      err_r      <= `QPC_ERR_NONE;
      irq_stat_r <= {`QPC_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      count_r <= count_nxt;
      err_r   <= err_nxt;
      if (wr_en && paddr == `QPC_OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[`QPC_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule
`default_nettype wire

//--- verification/qpc_counter_props.sv
// checker for the counter's apb, count and interrupt behaviour
// assumes binding to qpc_counter; sees its ports only
`timescale 1ns/10ps
`default_nettype none
`include "qpc_map.vh"

module qpc_counter_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        phase_a,
  input wire logic        phase_b,
  input wire logic        preset_pin,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // shadows of written control and mask bits
  // ****************************************************************
  logic [2:0] en_r;
  logic [2:0] perr_r;
  logic [1:0] msk_r;
  logic [7:0] ctl_s;
  wire        wc    = psel & penable & pready & pwrite & (paddr == `QPC_OFS_CTRL);
  wire        wm    = psel & penable & pready & pwrite & (paddr == `QPC_OFS_IRQ_MASK);
  wire        rd_ok = pready & ~pwrite;
  wire        req_w = pwdata[7] & ~ctl_s[7] & ~ctl_s[6];
  wire        mul_w = pwdata[2:1] == `QPC_MODE_QUAD && pwdata[4:3] == `QPC_MUL_BAD;
  // the enable and source that gate a request are those stored before the write
  wire        perr  = ~ctl_s[0] & ~pwdata[0] & (req_w | (perr_r[0] & ~mul_w));
  // delayed copies cover the internal latency before a write shows
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 3'h0;
      perr_r <= 3'h0;
      msk_r <= 2'h0;
      ctl_s <= 8'h00;
    end else begin
      en_r <= {en_r[1:0], wc ? pwdata[0] : en_r[0]};
      perr_r <= {perr_r[1:0], wc ? perr : perr_r[0]};
      msk_r <= {msk_r[0], wm ? |pwdata[3:0] : msk_r[0]};
      ctl_s <= wc ? pwdata[7:0] : ctl_s;
    end
  end
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access");
  unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr)
    else $error("no pslverr on unmapped address");
  mapped_ok_a: assert property (rd_ok && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr on mapped read");
  rdata_hold_a: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("prdata moved without read setup");
  count_width_a: assert property (
    rd_ok && paddr == `QPC_OFS_COUNT |-> prdata[31:24] == 8'h00)
    else $error("count wider than 24 bits");
  count_clear_a: assert property (
    rd_ok && paddr == `QPC_OFS_COUNT && en_r == 3'h0 |-> prdata[23:0] == 24'h000000)
    else $error("count not zero while disabled");
  preset_err_a: assert property (
    rd_ok && paddr == `QPC_OFS_ERR && perr_r == 3'h7 |-> prdata[7:0] == `QPC_ERR_DISABLED)
    else $error("no error code for preset while disabled");
  irq_masked_a: assert property (msk_r == 2'h0 |-> !irq)
    else $error("irq high with mask clear");
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (rd_ok && paddr == `QPC_OFS_COUNT && prdata[23:0] == 24'hFFFFFF);
  cover property ($rose(preset_pin));
  cover property (phase_a && phase_b);
endmodule

bind qpc_counter qpc_counter_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .phase_a(phase_a), .phase_b(phase_b),
  .preset_pin(preset_pin), .irq(irq));
`default_nettype wire

//--- verification/qpc_encoder.sv
// encoder and preset source model driving the counter's pins
// assumes its tasks are called just after a rising pclk edge
`timescale 1ns/10ps
`default_nettype none

module qpc_encoder (
  input  wire logic pclk,
  output var logic  phase_a,
  output var logic  phase_b,
  output var logic  preset_pin
);
  // pins idle low until a task moves them
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    preset_pin = 1'b0;
  end
  // six clocks per level, well past the sync and step latency
  task hold;
    repeat (6) @(posedge pclk);
  endtask
  // gray steps: a leads b when counting up
  task quad(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      if ((phase_a == phase_b) == up) phase_a <= ~phase_a;
      else phase_b <= ~phase_b;
      hold;
    end
  endtask
  task pulse(input int n);
    for (int i = 0; i < n; i++) begin
      phase_a <= 1'b1;
      hold;
      phase_a <= 1'b0;
      hold;
    end
  endtask
  task set_b(input logic v);
    phase_b <= v;
    hold;
  endtask
  task pre;
    preset_pin <= 1'b1;
    hold;
    preset_pin <= 1'b0;
    hold;
  endtask
endmodule
`default_nettype wire

//--- verification/qpc_counter_bench.sv
// self-checking bench for the quadrature pulse counter
// assumes the counter, its checker and the encoder model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "qpc_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

module qpc_counter_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         phase_a;
  wire         phase_b;
  wire         preset_pin;
  wire         irq;
  logic [31:0] rdq;
  logic        errq;
  int          failures;
  int          cmp_count;

  qpc_counter i_qpc_counter (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_a(phase_a), .phase_b(phase_b), .preset_pin(preset_pin),
    .irq(irq));
  qpc_encoder i_qpc_encoder (.pclk(pclk), .phase_a(phase_a), .phase_b(phase_b),
    .preset_pin(preset_pin));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task wrap_up;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one transfer, then an idle cycle so no strobe is driven twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      failures++;
      wrap_up;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdq, e)
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 24; a += 4) chk_rd(a[7:0], 32'h0);
    chk_rd(8'h20, 32'h0);
    `CHK(errq, 1'b1)
    // preset while disabled, then raise, mask and clear the interrupt
    wr(`QPC_OFS_IRQ_MASK, 32'h2);
    wr(`QPC_OFS_CTRL, 32'h80);
    chk_rd(`QPC_OFS_ERR, 32'h4);
    chk_rd(`QPC_OFS_COUNT, 32'h0);
    `CHK(irq, 1'b1)
    wr(`QPC_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    chk_rd(`QPC_OFS_IRQ_STAT, 32'h2);
    wr(`QPC_OFS_IRQ_STAT, 32'h2);
    chk_rd(`QPC_OFS_IRQ_STAT, 32'h0);
    // one-phase modes; multiplier set but ignored here
    wr(`QPC_OFS_CTRL, 32'h11);
    i_qpc_encoder.pulse(5);
    chk_rd(`QPC_OFS_COUNT, 32'h5);
    wr(`QPC_OFS_CTRL, 32'h21);
    i_qpc_encoder.pulse(2);
    chk_rd(`QPC_OFS_COUNT, 32'h3);
    wr(`QPC_OFS_CTRL, 32'h03);
    i_qpc_encoder.pulse(1);
    chk_rd(`QPC_OFS_COUNT, 32'h4);
    i_qpc_encoder.set_b(1'b1);
    i_qpc_encoder.pulse(2);
    chk_rd(`QPC_OFS_COUNT, 32'h2);
    i_qpc_encoder.set_b(1'b0);
    // quadrature, one full cycle up and back for each multiplier
    for (int m = 0; m < 3; m++) begin
      wr(`QPC_OFS_CTRL, 32'h0);
      chk_rd(`QPC_OFS_COUNT, 32'h0);
      wr(`QPC_OFS_CTRL, 32'h05 | (m << 3));
      i_qpc_encoder.quad(4, 1'b1);
      chk_rd(`QPC_OFS_COUNT, 32'h1 << m);
      i_qpc_encoder.quad(4, 1'b0);
      chk_rd(`QPC_OFS_COUNT, 32'h0);
    end
    // undefined multiplier in quadrature: error code and no counting
    wr(`QPC_OFS_CTRL, 32'h1D);
    i_qpc_encoder.quad(4, 1'b1);
    chk_rd(`QPC_OFS_COUNT, 32'h0);
    chk_rd(`QPC_OFS_ERR, 32'h2);
    // program preset to full scale, then wrap past it
    wr(`QPC_OFS_PRESET, 32'hFFFFFF);
    wr(`QPC_OFS_CTRL, 32'h01);
    wr(`QPC_OFS_CTRL, 32'h81);
    chk_rd(`QPC_OFS_COUNT, 32'hFFFFFF);
    chk_rd(`QPC_OFS_ERR, 32'h0);
    i_qpc_encoder.pulse(1);
    chk_rd(`QPC_OFS_COUNT, 32'h0);
    chk_rd(`QPC_OFS_IRQ_STAT, 32'h5);
    wr(`QPC_OFS_IRQ_STAT, 32'hF);
    // pin preset: program request ignored
    wr(`QPC_OFS_PRESET, 32'h123456);
    wr(`QPC_OFS_CTRL, 32'h41);
    wr(`QPC_OFS_CTRL, 32'hC1);
    chk_rd(`QPC_OFS_COUNT, 32'h0);
    i_qpc_encoder.pre();
    chk_rd(`QPC_OFS_COUNT, 32'h123456);
    wrap_up;
  end
endmodule
`default_nettype wire
